// >>> verilog/ccdrr_defs.svh
// Constants for the clock router: supply settle timing, collection phase and reset values
// Behaviour
// [R1] Section A forward: phases 1-4 direct, upper gate phase 4
// [R2] Section D forward: phases 1-4 direct, lower gate phase 1
// [R3] Split: B direct upward, C direct downward
// [R4] Section A reversed: phases reversed, upper gate low
// [R5] Section D reversed: phases reversed, lower gate low
// [R6] B downward or C upward: phases reversed
// [R7] Whole array upper: A,B forward, C,D reversed
// [R8] Mode set only by routed pulse sequences
// [R9] Register electrodes 1,2 high during line transfer
// [R10] Own output: phase1 to e2, phase2 to e1
// [R11] Reversed half-section: phases 1-3 straight
// [R12] Four outputs: all own, any single reversible
// [R13] No summing: summing gate follows register phase 3
// [R14] Summing: hold gate high N cycles, then release
// [R15] Power-up: drains up before substrate rises
// [R16] Power-down: substrate to zero before drains
// [R17] Integration: all phases held static
// [R18] Collection: image phases 2 and 3 held high
// [R19] Routing from one mode, changed only while static
`ifndef CCDRR_DEFS_SVH
`define CCDRR_DEFS_SVH
// ==========================================
// Supply sequencing
`define CCDRR_SETTLE_US        100
`define CCDRR_CLK_MHZ          20
`define CCDRR_SETTLE_CYC       (`CCDRR_SETTLE_US * `CCDRR_CLK_MHZ)
`define CCDRR_CNT_W            16
// ==========================================
// Reset values and collection phase
`define CCDRR_PHASE_RST        4'h0
`define CCDRR_COLLECT_PHASE    4'h6
`define CCDRR_DIR_RST          4'h0
`define CCDRR_REV_RST          4'h0
`endif

// >>> verilog/ccdrr_pkg.sv
// Types for the clock router
package ccdrr_pkg;
   typedef enum logic [1:0] {ccdrr_off, ccdrr_drains_up, ccdrr_on, ccdrr_sub_down} ccdrr_pwr_e;
   typedef enum logic [1:0] {ccdrr_static, ccdrr_parallel, ccdrr_serial} ccdrr_act_e;
endpackage : ccdrr_pkg

// >>> verilog/ccdrr_router.sv
// Phase-to-electrode router and supply sequencer for a four-section sensor
`timescale 1ns/100ps
`include "ccdrr_defs.svh"
module ccdrr_router
   import ccdrr_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       power_req,
   input  wire logic [1:0] activity,
   input  wire logic [3:0] mode_dir,
   input  wire logic [3:0] mode_rev,
   input  wire logic [3:0] img_phase,
   input  wire logic [2:0] reg_phase,
   input  wire logic       sum_en,
   input  wire logic [1:0] sum_sel,
   input  wire logic [7:0] sum_count,
   input  wire logic       sum_pixel,
   output logic [3:0]      sec_a,
   output logic [3:0]      sec_b,
   output logic [3:0]      sec_c,
   output logic [3:0]      sec_d,
   output logic            upper_transfer_gate,
   output logic            lower_transfer_gate,
   output logic [2:0]      half_e,
   output logic [2:0]      half_f,
   output logic [2:0]      half_g,
   output logic [2:0]      half_h,
   output logic [3:0]      summing_well_gate,
   output logic            drains_on,
   output logic            substrate_on,
   output logic            mode_busy
);
   // ==========================================
   // Helpers
   function automatic logic [3:0] ccdrr_img_map(input logic [3:0] ph, input logic rev);
      ccdrr_img_map = rev ? {ph[0], ph[1], ph[2], ph[3]} : ph;  // R4 R5 R6
   endfunction : ccdrr_img_map

   function automatic logic [2:0] ccdrr_reg_map(input logic [2:0] ph, input logic rev, input logic xfer);
      if (xfer) begin
         ccdrr_reg_map = {ph[2], 2'b11};  // R9
      end else if (rev) begin
         ccdrr_reg_map = ph;  // R11
      end else begin
         ccdrr_reg_map = {ph[2], ph[0], ph[1]};  // R10
      end
   endfunction : ccdrr_reg_map

   // ==========================================
   // Latched routing
   logic [3:0]  dir_q;
   logic [3:0]  rev_q;
   ccdrr_pwr_e  pwr;
   ccdrr_act_e  act;
   assign act = ccdrr_act_e'(activity);
   assign mode_busy = (act != ccdrr_static);

   // Mode latched only while static so no phase glitches mid-transfer
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dir_q <= `CCDRR_DIR_RST;
         rev_q <= `CCDRR_REV_RST;
      end else if (!mode_busy) begin  // R19 R8
         dir_q <= mode_dir;
         rev_q <= mode_rev;
      end
   end

   // ==========================================
   // Image outputs
   // dir bit per section: 1 = away from its natural register
   logic        running;
   logic [3:0]  ph;
   assign running = substrate_on || (pwr == ccdrr_on);
   assign ph = (act == ccdrr_parallel) ? img_phase : `CCDRR_COLLECT_PHASE;  // R17 R18

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sec_a <= `CCDRR_PHASE_RST;
         sec_b <= `CCDRR_PHASE_RST;
         sec_c <= `CCDRR_PHASE_RST;
         sec_d <= `CCDRR_PHASE_RST;
         upper_transfer_gate <= 1'b0;
         lower_transfer_gate <= 1'b0;
      end else if (running) begin
         sec_a <= ccdrr_img_map(ph, dir_q[0]);  // R1 R4 R7
         sec_b <= ccdrr_img_map(ph, dir_q[1]);  // R3 R6 R7
         sec_c <= ccdrr_img_map(ph, dir_q[2]);  // R3 R6 R7
         sec_d <= ccdrr_img_map(ph, dir_q[3]);  // R2 R5 R7
         upper_transfer_gate <= dir_q[0] ? 1'b0 : ph[3];  // R1 R4
         lower_transfer_gate <= dir_q[3] ? 1'b0 : ph[0];  // R2 R5
      end else begin
         sec_a <= `CCDRR_PHASE_RST;
         sec_b <= `CCDRR_PHASE_RST;
         sec_c <= `CCDRR_PHASE_RST;
         sec_d <= `CCDRR_PHASE_RST;
         upper_transfer_gate <= 1'b0;
         lower_transfer_gate <= 1'b0;
      end
   end

   // ==========================================
   // Register outputs
   logic       xfer;
   logic [2:0] rph;
   assign xfer = (act == ccdrr_parallel);
   assign rph = (act == ccdrr_serial) ? reg_phase : 3'h0;  // R17

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         half_e <= 3'h0;
         half_f <= 3'h0;
         half_g <= 3'h0;
         half_h <= 3'h0;
      end else if (running) begin
         half_e <= ccdrr_reg_map(rph, rev_q[0], xfer);  // R12
         half_f <= ccdrr_reg_map(rph, rev_q[1], xfer);  // R12
         half_g <= ccdrr_reg_map(rph, rev_q[2], xfer);  // R12
         half_h <= ccdrr_reg_map(rph, rev_q[3], xfer);  // R12
      end else begin
         half_e <= 3'h0;
         half_f <= 3'h0;
         half_g <= 3'h0;
         half_h <= 3'h0;
      end
   end

   // ==========================================
   // Summing well
   logic [7:0] sum_left;
   logic       pix_d;
   logic       holding;
   assign holding = sum_en && (sum_left != 8'h00);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sum_left <= 8'h00;
         pix_d <= 1'b0;
      end else begin
         pix_d <= sum_pixel;
         if (!sum_en || !mode_busy) begin
            sum_left <= sum_count;
         end else if (sum_pixel && !pix_d && holding) begin
            sum_left <= sum_left - 8'h01;  // R14
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sw
         always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               summing_well_gate[gi] <= 1'b0;
            end else if (!running) begin
               summing_well_gate[gi] <= 1'b0;
            end else if (holding && (sum_sel == 2'(gi))) begin
               summing_well_gate[gi] <= 1'b1;  // R14
            end else begin
               summing_well_gate[gi] <= rph[2];  // R13
            end
         end
      end
   endgenerate

   // ==========================================
   // Supply sequencing
   logic [`CCDRR_CNT_W-1:0]  settle;
   logic                     settled;
   assign settled = (settle == `CCDRR_CNT_W'(`CCDRR_SETTLE_CYC));

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         settle <= '0;
      end else if ((pwr == ccdrr_drains_up) || (pwr == ccdrr_sub_down)) begin
         if (!settled) begin
            settle <= settle + `CCDRR_CNT_W'(1);
         end
      end else begin
         settle <= '0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pwr <= ccdrr_off;
      end else begin
         unique case (pwr)
            ccdrr_off:       if (power_req) pwr <= ccdrr_drains_up;
            ccdrr_drains_up: if (settled) pwr <= ccdrr_on;  // R15
            ccdrr_on:        if (!power_req) pwr <= ccdrr_sub_down;
            ccdrr_sub_down:  if (settled) pwr <= ccdrr_off;  // R16
         endcase
      end
   end

   assign drains_on = (pwr != ccdrr_off);
   assign substrate_on = (pwr == ccdrr_on);

   // ==========================================
   // Checks
   property p_sub_after_drains;
      @(posedge clock) disable iff (!rst_n) substrate_on |-> drains_on;
   endproperty
   a_sub_after_drains: assert property (p_sub_after_drains) else $error("substrate up without drains"); // R15

   property p_drains_hold;
      @(posedge clock) disable iff (!rst_n) $fell(substrate_on) |-> drains_on [*8];
   endproperty
   a_drains_hold: assert property (p_drains_hold) else $error("drains dropped with substrate"); // R16

   property p_mode_static;
      @(posedge clock) disable iff (!rst_n) mode_busy |=> $stable(dir_q) && $stable(rev_q);
   endproperty
   a_mode_static: assert property (p_mode_static) else $error("routing changed while clocking"); // R19

   property p_tga_low_rev;
      @(posedge clock) disable iff (!rst_n) dir_q[0] && $stable(dir_q) |=> !upper_transfer_gate;
   endproperty
   a_tga_low_rev: assert property (p_tga_low_rev) else $error("upper gate not low when reversed"); // R4

   property p_collect;
      @(posedge clock) disable iff (!rst_n) running && act == ccdrr_static && $stable(running) |=> sec_a[1] && sec_a[2];
   endproperty
   a_collect: assert property (p_collect) else $error("collection phases not high"); // R18

   property p_xfer_high;
      @(posedge clock) disable iff (!rst_n) running && xfer && $stable(running) |=> half_e[1:0] == 2'b11;
   endproperty
   a_xfer_high: assert property (p_xfer_high) else $error("register not high in transfer"); // R9

   property p_own_map;
      @(posedge clock) disable iff (!rst_n)
         running && act == ccdrr_serial && !rev_q[1] && $stable(rev_q) && $stable(running) |=> half_f[1] == $past(reg_phase[0]);
   endproperty
   a_own_map: assert property (p_own_map) else $error("own-output map wrong"); // R10

   property p_sw_follow;
      @(posedge clock) disable iff (!rst_n) running && !sum_en && $stable(running) |=> summing_well_gate[0] == half_e[2];
   endproperty
   a_sw_follow: assert property (p_sw_follow) else $error("summing gate not following phase 3"); // R13

   // ==========================================
   // Supply order, built from steps
   sequence s_drains_rise;
      $rose(drains_on) && !substrate_on;
   endsequence

   sequence s_settle_wait;
      !substrate_on [*8];
   endsequence

   property p_power_up;
      @(posedge clock) disable iff (!rst_n)
         s_drains_rise |-> s_settle_wait;
   endproperty
   a_power_up: assert property (p_power_up) else $error("substrate rose without drain settle"); // R15

   property p_drains_off_late;
      @(posedge clock) disable iff (!rst_n)
         $fell(drains_on) |-> $past(substrate_on, 8) == 1'b0;
   endproperty
   a_drains_off_late: assert property (p_drains_off_late) else $error("drains removed too soon"); // R16

   // Unpowered electrodes must sit low so no charge moves on a cold sensor
   property p_unpowered;
      @(posedge clock) disable iff (!rst_n)
         !running |=> (sec_a == 4'h0) && (half_e == 3'h0) && (summing_well_gate == 4'h0);
   endproperty
   a_unpowered: assert property (p_unpowered) else $error("electrodes driven while unpowered"); // R16

   // ==========================================
   // Image routing
   property p_sec_a_fwd;
      @(posedge clock) disable iff (!rst_n)
         running && !dir_q[0] |=> sec_a == $past(ph);
   endproperty
   a_sec_a_fwd: assert property (p_sec_a_fwd) else $error("section A forward map wrong"); // R1

   property p_sec_a_rev;
      @(posedge clock) disable iff (!rst_n)
         running && dir_q[0] |=> sec_a[3] == $past(ph[0]);
   endproperty
   a_sec_a_rev: assert property (p_sec_a_rev) else $error("section A reverse map wrong"); // R4

   property p_upper_fwd;
      @(posedge clock) disable iff (!rst_n)
         running && !dir_q[0] |=> upper_transfer_gate == $past(ph[3]);
   endproperty
   a_upper_fwd: assert property (p_upper_fwd) else $error("upper gate not on phase 4"); // R1

   property p_lower_fwd;
      @(posedge clock) disable iff (!rst_n)
         running && !dir_q[3] |=> lower_transfer_gate == $past(ph[0]);
   endproperty
   a_lower_fwd: assert property (p_lower_fwd) else $error("lower gate not on phase 1"); // R2

   property p_lower_rev;
      @(posedge clock) disable iff (!rst_n)
         dir_q[3] |=> !lower_transfer_gate;
   endproperty
   a_lower_rev: assert property (p_lower_rev) else $error("lower gate not low when reversed"); // R5

   property p_sec_d_rev;
      @(posedge clock) disable iff (!rst_n)
         running && dir_q[3] |=> sec_d[3] == $past(ph[0]);
   endproperty
   a_sec_d_rev: assert property (p_sec_d_rev) else $error("section D reverse map wrong"); // R5

   property p_sec_b_fwd;
      @(posedge clock) disable iff (!rst_n)
         running && !dir_q[1] |=> sec_b == $past(ph);
   endproperty
   a_sec_b_fwd: assert property (p_sec_b_fwd) else $error("section B forward map wrong"); // R3

   property p_sec_c_fwd;
      @(posedge clock) disable iff (!rst_n)
         running && !dir_q[2] |=> sec_c == $past(ph);
   endproperty
   a_sec_c_fwd: assert property (p_sec_c_fwd) else $error("section C forward map wrong"); // R3

   property p_sec_c_rev;
      @(posedge clock) disable iff (!rst_n)
         running && dir_q[2] |=> sec_c[0] == $past(ph[3]);
   endproperty
   a_sec_c_rev: assert property (p_sec_c_rev) else $error("section C reverse map wrong"); // R6

   property p_sec_b_rev;
      @(posedge clock) disable iff (!rst_n)
         running && dir_q[1] |=> sec_b[0] == $past(ph[3]);
   endproperty
   a_sec_b_rev: assert property (p_sec_b_rev) else $error("section B reverse map wrong"); // R6

   // ==========================================
   // Register routing
   property p_xfer_high_g;
      @(posedge clock) disable iff (!rst_n)
         running && xfer |=> half_g[1:0] == 2'b11;
   endproperty
   a_xfer_high_g: assert property (p_xfer_high_g) else $error("register G not high in transfer"); // R9

   property p_rev_map;
      @(posedge clock) disable iff (!rst_n)
         running && (act == ccdrr_serial) && rev_q[0] |=> half_e == $past(reg_phase);
   endproperty
   a_rev_map: assert property (p_rev_map) else $error("reversed half map wrong"); // R11

   property p_own_map_h;
      @(posedge clock) disable iff (!rst_n)
         running && (act == ccdrr_serial) && !rev_q[3] |=> half_h[0] == $past(reg_phase[1]);
   endproperty
   a_own_map_h: assert property (p_own_map_h) else $error("own-output map wrong on H"); // R12

   property p_static_reg;
      @(posedge clock) disable iff (!rst_n)
         (act == ccdrr_static) |=> (half_e == 3'h0) && (half_h == 3'h0);
   endproperty
   a_static_reg: assert property (p_static_reg) else $error("register phases moving while static"); // R17

   // ==========================================
   // Summing hold
   sequence s_sum_armed;
      running && holding && (sum_sel == 2'h2);
   endsequence

   property p_sum_hold;
      @(posedge clock) disable iff (!rst_n)
         s_sum_armed |=> summing_well_gate[2];
   endproperty
   a_sum_hold: assert property (p_sum_hold) else $error("summing gate not held high"); // R14

endmodule : ccdrr_router

// >>> verification/ccdrr_sensor_model.sv
// Behavioural model of the four-section sensor seen from its supply and electrode pins
`timescale 1ns/100ps
module ccdrr_sensor_model (
   input  wire logic       clock,
   input  wire logic       drains_on,
   input  wire logic       substrate_on,
   input  wire logic [3:0] sec_a,
   input  wire logic [2:0] half_e,
   output logic            order_fault
);
   // ==========================================
   // Electrodes
   // No mode state held here; charge simply follows the electrode levels
   logic [3:0] last_sec;
   logic [2:0] last_half;
   always_ff @(posedge clock) begin
      last_sec  <= sec_a;
      last_half <= half_e;
   end
   // ==========================================
   // Supplies
   // Substrate up with drains down would bias the drains negative
   initial order_fault = 1'b0;
   always_ff @(posedge clock) begin
      if (substrate_on && !drains_on) begin
         order_fault <= 1'b1;
      end
   end
endmodule : ccdrr_sensor_model

// >>> verification/testbench.sv
// Self-checking bench for the clock router
`timescale 1ns/100ps
module testbench;
   typedef struct {logic [3:0] dir; logic [3:0] rev; logic [3:0] ip; logic [2:0] rp;} ccdrr_row_s;
   logic clock, rst_n, power_req, sum_en, sum_pixel, utg, ltg, drains_on, substrate_on, mode_busy, fault;
   logic [1:0] activity, sum_sel;
   logic [3:0] mode_dir, mode_rev, img_phase, sec_a, sec_b, sec_c, sec_d, swg;
   logic [2:0] reg_phase, half_e, half_f, half_g, half_h;
   logic [7:0] sum_count;
   int fail_count = 0;
   int cmp_count  = 0;
   int cycles     = 0;
   ccdrr_row_s rows [5] = '{'{4'h0, 4'h0, 4'h9, 3'h5}, '{4'hf, 4'hf, 4'h9, 3'h3},
      '{4'hc, 4'h0, 4'h8, 3'h6}, '{4'h3, 4'h1, 4'h1, 3'h1}, '{4'h6, 4'h4, 4'h3, 3'h2}};
   ccdrr_router dut_u (.clock(clock), .rst_n(rst_n), .power_req(power_req), .activity(activity),
      .mode_dir(mode_dir), .mode_rev(mode_rev), .img_phase(img_phase), .reg_phase(reg_phase),
      .sum_en(sum_en), .sum_sel(sum_sel), .sum_count(sum_count), .sum_pixel(sum_pixel),
      .sec_a(sec_a), .sec_b(sec_b), .sec_c(sec_c), .sec_d(sec_d), .upper_transfer_gate(utg),
      .lower_transfer_gate(ltg), .half_e(half_e), .half_f(half_f), .half_g(half_g), .half_h(half_h),
      .summing_well_gate(swg), .drains_on(drains_on), .substrate_on(substrate_on), .mode_busy(mode_busy));
   ccdrr_sensor_model model_u (.clock(clock), .drains_on(drains_on), .substrate_on(substrate_on),
      .sec_a(sec_a), .half_e(half_e), .order_fault(fault));
   // ==========================================
   // Helpers
   function automatic logic [3:0] img(input logic rev, input logic [3:0] p);
      img = rev ? {p[0], p[1], p[2], p[3]} : p;
   endfunction : img
   function automatic logic [3:0] hlf(input logic rev, input logic [2:0] p);
      hlf = rev ? {1'b0, p} : {1'b0, p[2], p[0], p[1]};
   endfunction : hlf
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #5;
   endtask : step
   task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", name, exp, got);
         fail_count++;
      end
   endtask : chk
   task automatic results;
      if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : results
   // ==========================================
   // Clock and timeout
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 12000) begin
         fail_count++;
         results();
      end
   end
   // ==========================================
   // Sequence
   initial begin
      {rst_n, power_req, activity, mode_dir, mode_rev, sum_en, sum_sel, sum_count, sum_pixel} = '0;
      img_phase = 4'hf;
      reg_phase = 3'h7;
      repeat (6) @(posedge clock);
      chk("sec_a in reset", 4'h0, sec_a);
      #5 rst_n = 1'b1;
      step(2);
      chk("sec_a unpowered", 4'h0, sec_a);
      power_req = 1'b1;
      step(1);
      chk("drains early", 4'h1, {3'h0, drains_on & ~substrate_on});
      step(1990);
      chk("substrate early", 4'h0, {3'h0, substrate_on});
      step(20);
      chk("substrate up", 4'h1, {3'h0, substrate_on});
      foreach (rows[i]) begin
         activity = 2'h0;
         mode_dir = rows[i].dir;
         mode_rev = rows[i].rev;
         step(3);
         chk("collect a", 4'h6, sec_a);
         chk("collect d", 4'h6, sec_d);
         activity  = 2'h1;
         img_phase = rows[i].ip;
         step(2);
         chk("busy", 4'h1, {3'h0, mode_busy});
         chk("sec_a", img(rows[i].dir[0], rows[i].ip), sec_a);
         chk("sec_b", img(rows[i].dir[1], rows[i].ip), sec_b);
         chk("sec_c", img(rows[i].dir[2], rows[i].ip), sec_c);
         chk("sec_d", img(rows[i].dir[3], rows[i].ip), sec_d);
         chk("upper gate", {3'h0, ~rows[i].dir[0] & rows[i].ip[3]}, {3'h0, utg});
         chk("lower gate", {3'h0, ~rows[i].dir[3] & rows[i].ip[0]}, {3'h0, ltg});
         chk("line transfer", 4'h3, {1'b0, half_e});
         chk("line transfer h", 4'h3, {1'b0, half_h});
         activity  = 2'h2;
         reg_phase = rows[i].rp;
         step(2);
         chk("half_e", hlf(rows[i].rev[0], rows[i].rp), {1'b0, half_e});
         chk("half_f", hlf(rows[i].rev[1], rows[i].rp), {1'b0, half_f});
         chk("half_g", hlf(rows[i].rev[2], rows[i].rp), {1'b0, half_g});
         chk("half_h", hlf(rows[i].rev[3], rows[i].rp), {1'b0, half_h});
         chk("sum gate", {4{rows[i].rp[2]}}, swg);
      end
      // Mode change during transfer must be ignored
      activity  = 2'h1;
      img_phase = 4'h3;
      step(1);
      mode_dir = 4'h9;
      step(3);
      chk("sec_a held mode", 4'h3, sec_a);
      activity = 2'h0;
      mode_rev = 4'h0;
      sum_en = 1'b1;
      sum_sel = 2'h2;
      sum_count = 8'h03;
      step(3);
      activity  = 2'h2;
      reg_phase = 3'h0;
      step(2);
      chk("sum hold", 4'h4, swg);
      repeat (2) begin
         sum_pixel = 1'b1;
         step(1);
         sum_pixel = 1'b0;
         step(1);
      end
      chk("sum still held", 4'h4, swg);
      sum_pixel = 1'b1;
      step(1);
      sum_pixel = 1'b0;
      step(3);
      chk("sum released", 4'h0, swg);
      reg_phase = 3'h4;
      step(2);
      chk("sum follows", 4'hf, swg);
      power_req = 1'b0;
      step(2);
      chk("down order", 4'h1, {3'h0, drains_on & ~substrate_on});
      chk("sec_a off", 4'h0, sec_a);
      step(1900);
      chk("drains held", 4'h1, {3'h0, drains_on});
      step(200);
      chk("drains off", 4'h0, {3'h0, drains_on});
      chk("supply order", 4'h0, {3'h0, fault});
      results();
   end
endmodule : testbench
